/* rtl/flash_extended_query_rom.v */
// extended query table of a parallel flash, with pin-side query reads and
// an Avalon-MM register window; assumes one 50 MHz clock and async pins
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "query_rom_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - query reads at 10Ah..10Ch return signature bytes 50h 52h 49h
// - query address 10Dh returns major version character 31h
// - query address 10Eh returns minor version character 35h
// - feature field is four bytes, least significant first, 1 means supported
// - low feature byte at 10Fh reads E6h
// - second feature byte at 110h reads 01h
// - feature bits 11 to 29 and undefined bits read zero
// - feature bit 31 set means another field follows; host parses only then
// - while suspended, status and query reads stay available; array reads return the status byte
// - suspend-functions byte at 113h reads 01h, upper bits zero
// - block status mask at 114h/115h reads 0003h
// - block status mask bits 2 to 15 read zero
// - byte at 116h reads 30h, meaning 3.0 volts
module flash_extended_query_rom
#(
   parameter [7:0] FEAT_TOP_BYTE = `QV_FEAT3,
   parameter       PIN_CNT_W     = 16
)
(
   input  wire                 ref_clk,
   input  wire                 rst_n,
   input  wire                 clk_en,
   // avalon-mm slave
   input  wire [2:0]           address,
   input  wire                 read,
   input  wire                 write,
   input  wire [31:0]          writedata,
   output reg  [31:0]          readdata,
   output reg                  waitrequest,
   // flash pins
   input  wire [8:0]           pin_addr,
   input  wire                 pin_ce_n,
   input  wire                 pin_oe_n,
   output reg  [15:0]          dq_out,
   output reg                  dq_oe,
   // array and status sources from same-clock logic
   input  wire [15:0]          array_rdata,
   input  wire [7:0]           status_byte
);

   localparam PIN_W = `QADDR_W + 2;
   localparam [8:0] QADDR_STEP = 9'h001;
   localparam [PIN_CNT_W-1:0] PIN_CNT_STEP = {{(PIN_CNT_W-1){1'b0}}, 1'b1};

   // pin read states
   localparam [1:0] PS_IDLE  = 2'b00;
   localparam [1:0] PS_DRIVE = 2'b01;
   localparam [1:0] PS_HOLD  = 2'b10;

   // bus answer states
   localparam BS_WAIT = 1'b0;
   localparam BS_ACK  = 1'b1;

   reg  [1:0]               ctrl_reg;
   reg  [1:0]               ctrl_next;
   reg  [8:0]               qaddr_reg;
   reg  [8:0]               qaddr_next;
   reg  [PIN_CNT_W-1:0]     pin_cnt_reg;
   reg  [PIN_CNT_W-1:0]     pin_cnt_next;
   reg  [1:0]               pstate_reg;
   reg  [1:0]               pstate_next;
   reg                      bstate_reg;
   reg                      bstate_next;
   reg  [31:0]              rdata_next;
   reg  [15:0]              dq_next;
   reg                      dq_oe_next;

   wire [PIN_W-1:0]         pin_raw;
   wire [PIN_W-1:0]         pin_stable;
   wire [8:0]               pin_addr_s;
   wire                     pin_ce_n_s;
   wire                     pin_oe_n_s;
   wire                     pin_read;
   wire [7:0]               bus_qbyte;
   wire [7:0]               pin_qbyte;
   wire [31:0]              feat_word;
   wire                     query_mode;
   wire                     suspended;
   wire                     req;
   wire                     wr_take;

   ////////////////////////////////////////////////////////////////////////////
   // pin input synchronisers: a change counts once stages two and three agree

   assign pin_raw = {pin_oe_n, pin_ce_n, pin_addr};

   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi = gi + 1)
      begin : g_pin_sync
         reg [`SYNC_STAGES-1:0] sync_reg;
         reg                    stable_reg;
         always @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               sync_reg   <= {`SYNC_STAGES{1'b1}};
               stable_reg <= 1'b1;
            end
            else if (clk_en)
            begin
               sync_reg <= {sync_reg[`SYNC_STAGES-2:0], pin_raw[gi]};
               if (sync_reg[`SYNC_STAGES-2] == sync_reg[`SYNC_STAGES-1])
                  stable_reg <= sync_reg[`SYNC_STAGES-1];
            end
         end
         assign pin_stable[gi] = stable_reg;
      end
   endgenerate

   assign pin_addr_s = pin_stable[`QADDR_W-1:0];
   assign pin_ce_n_s = pin_stable[`QADDR_W];
   assign pin_oe_n_s = pin_stable[`QADDR_W+1];
   assign pin_read   = ~pin_ce_n_s & ~pin_oe_n_s;

   ////////////////////////////////////////////////////////////////////////////
   // table lookups for the bus port and the pin port

   query_byte_lut
   #(
      .FEAT_TOP_BYTE (FEAT_TOP_BYTE)
   )
   u_bus_lut
   (
      .qaddr (qaddr_reg),
      .qbyte (bus_qbyte)
   );

   query_byte_lut
   #(
      .FEAT_TOP_BYTE (FEAT_TOP_BYTE)
   )
   u_pin_lut
   (
      .qaddr (pin_addr_s),
      .qbyte (pin_qbyte)
   );

   // assembled feature field, least significant byte at the lowest address
   assign feat_word = {FEAT_TOP_BYTE, `QV_FEAT2, `QV_FEAT1, `QV_FEAT0};

   assign query_mode = ctrl_reg[`CTRL_QUERY_BIT];
   assign suspended  = ctrl_reg[`CTRL_SUSP_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // pin read path

   always @*
   begin
      pstate_next  = pstate_reg;
      dq_next      = dq_out;
      dq_oe_next   = 1'b0;
      pin_cnt_next = pin_cnt_reg;
      case (pstate_reg)
         PS_IDLE:
         begin
            if (pin_read)
            begin
               pstate_next  = PS_DRIVE;
               pin_cnt_next = pin_cnt_reg + PIN_CNT_STEP;
            end
         end
         PS_DRIVE:
         begin
            dq_oe_next = 1'b1;
            // suspend turns array reads into status byte reads; query mode still wins
            if (query_mode)
               dq_next = {8'h00, pin_qbyte};
            else if (suspended)
               dq_next = {8'h00, status_byte};
            else
               dq_next = array_rdata;
            pstate_next = PS_HOLD;
         end
         PS_HOLD:
         begin
            dq_oe_next = pin_read;
            if (pin_read)
            begin
               if (query_mode)
                  dq_next = {8'h00, pin_qbyte};
               else if (suspended)
                  dq_next = {8'h00, status_byte};
               else
                  dq_next = array_rdata;
            end
            else
               pstate_next = PS_IDLE;
         end
         default:
         begin
            pstate_next = PS_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // avalon-mm slave: one wait cycle, then the answer cycle

   assign req     = read | write;
   assign wr_take = write & (bstate_reg == BS_ACK);

   always @*
   begin
      bstate_next = bstate_reg;
      rdata_next  = readdata;
      case (bstate_reg)
         BS_WAIT:
         begin
            if (req)
            begin
               bstate_next = BS_ACK;
               if (read)
               begin
                  rdata_next = `ZERO32;
                  case (address)
                     `REG_CTRL:
                        rdata_next = {30'h0000_0000, ctrl_reg};
                     `REG_QADDR:
                        rdata_next = {23'h00_0000, qaddr_reg};
                     `REG_QDATA:
                     begin
                        if (query_mode)
                           rdata_next = {`ZERO16, 8'h00, bus_qbyte};
                        else if (suspended)
                           rdata_next = {`ZERO16, 8'h00, status_byte};
                        else
                           rdata_next = {`ZERO16, array_rdata};
                     end
                     `REG_STATUS:
                        rdata_next = {29'h0000_0000, pin_read, suspended, query_mode};
                     `REG_PIN_CNT:
                        rdata_next = {{(32-PIN_CNT_W){1'b0}}, pin_cnt_reg};
                     `REG_FEATURES:
                        rdata_next = feat_word;
                     default:
                        rdata_next = `ZERO32;
                  endcase
               end
            end
         end
         BS_ACK:
         begin
            bstate_next = BS_WAIT;
         end
         default:
         begin
            bstate_next = BS_WAIT;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // register writes and the query address auto-increment on data reads in query mode

   always @*
   begin
      ctrl_next  = ctrl_reg;
      qaddr_next = qaddr_reg;
      if (wr_take)
      begin
         case (address)
            `REG_CTRL:
               ctrl_next = writedata[1:0];
            `REG_QADDR:
               qaddr_next = writedata[`QADDR_W-1:0];
            default:
               ctrl_next = ctrl_reg;
         endcase
      end
      else if (read && bstate_reg == BS_ACK && address == `REG_QDATA && query_mode)
         qaddr_next = qaddr_reg + QADDR_STEP;
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_reg  <= `CTRL_RST;
         qaddr_reg <= `QADDR_RST;
      end
      else if (clk_en)
      begin
         ctrl_reg  <= ctrl_next;
         qaddr_reg <= qaddr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus answer registers

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bstate_reg  <= BS_WAIT;
         readdata    <= `ZERO32;
         waitrequest <= 1'b1;
      end
      else if (clk_en)
      begin
         bstate_reg  <= bstate_next;
         readdata    <= rdata_next;
         waitrequest <= ~(bstate_reg == BS_WAIT && req);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin read registers

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_cnt_reg <= `PIN_CNT_RST;
         pstate_reg  <= PS_IDLE;
         dq_out      <= `ZERO16;
         dq_oe       <= 1'b0;
      end
      else if (clk_en)
      begin
         pin_cnt_reg <= pin_cnt_next;
         pstate_reg  <= pstate_next;
         dq_out      <= dq_next;
         dq_oe       <= dq_oe_next;
      end
   end

endmodule // flash_extended_query_rom

/* rtl/query_byte_lut.v */
// lookup of one byte of the extended query table by query address
// assumes a stable address from registered logic; purely combinational
`timescale 1ns/1ps
`include "query_rom_regs.vh"

module query_byte_lut
#(
   parameter [7:0] FEAT_TOP_BYTE = `QV_FEAT3
)
(
   input  wire [8:0] qaddr,
   output reg  [7:0] qbyte
);

   always @*
   begin
      case (qaddr)
         `QA_SIG0:      qbyte = `QV_SIG0;
         `QA_SIG1:      qbyte = `QV_SIG1;
         `QA_SIG2:      qbyte = `QV_SIG2;
         `QA_VER_MAJOR: qbyte = `QV_VER_MAJOR;
         `QA_VER_MINOR: qbyte = `QV_VER_MINOR;
         `QA_FEAT0:     qbyte = `QV_FEAT0;
         `QA_FEAT1:     qbyte = `QV_FEAT1;
         `QA_FEAT2:     qbyte = `QV_FEAT2;
         `QA_FEAT3:     qbyte = FEAT_TOP_BYTE;
         `QA_SUSP_FUNC: qbyte = `QV_SUSP_FUNC;
         `QA_BLK_MASK0: qbyte = `QV_BLK_MASK0;
         `QA_BLK_MASK1: qbyte = `QV_BLK_MASK1;
         `QA_VCC_PE:    qbyte = `QV_VCC_PE;
         default:       qbyte = `QV_NONE;
      endcase
   end

endmodule // query_byte_lut

/* rtl/query_rom_regs.vh */
// constants of the extended query table and of its register window
// assumes word-addressed Avalon-MM access and a 50 MHz ref_clk
`ifndef QUERY_ROM_REGS_VH
`define QUERY_ROM_REGS_VH

// query table addresses
`define QA_SIG0        9'h10A
`define QA_SIG1        9'h10B
`define QA_SIG2        9'h10C
`define QA_VER_MAJOR   9'h10D
`define QA_VER_MINOR   9'h10E
`define QA_FEAT0       9'h10F
`define QA_FEAT1       9'h110
`define QA_FEAT2       9'h111
`define QA_FEAT3       9'h112
`define QA_SUSP_FUNC   9'h113
`define QA_BLK_MASK0   9'h114
`define QA_BLK_MASK1   9'h115
`define QA_VCC_PE      9'h116

// query table contents
`define QV_SIG0        8'h50
`define QV_SIG1        8'h52
`define QV_SIG2        8'h49
`define QV_VER_MAJOR   8'h31
`define QV_VER_MINOR   8'h35
`define QV_FEAT0       8'hE6
`define QV_FEAT1       8'h01
`define QV_FEAT2       8'h00
`define QV_FEAT3       8'h00
`define QV_SUSP_FUNC   8'h01
`define QV_BLK_MASK0   8'h03
`define QV_BLK_MASK1   8'h00
`define QV_VCC_PE      8'h30
`define QV_NONE        8'h00

// widths
`define QADDR_W        9
`define DQ_W           16
`define QBYTE_W        8
`define BUS_AW         3
`define BUS_DW         32
`define SYNC_STAGES    3

// register word indices
`define REG_CTRL       3'h0
`define REG_QADDR      3'h1
`define REG_QDATA      3'h2
`define REG_STATUS     3'h3
`define REG_PIN_CNT    3'h4
`define REG_FEATURES   3'h5

// field positions
`define CTRL_QUERY_BIT 0
`define CTRL_SUSP_BIT  1
`define ST_QUERY_BIT   0
`define ST_SUSP_BIT    1
`define ST_PIN_BIT     2
`define FEAT_MORE_BIT  31

// reset values
`define CTRL_RST       2'h0
`define QADDR_RST      9'h10A
`define PIN_CNT_RST    16'h0000
`define ZERO32         32'h0000_0000
`define ZERO16         16'h0000

`endif

/* verif/flash_extended_query_rom_tb.sv */
// self-checking bench: register model against the design
// assumes the design at its default parameters
`timescale 1ns/1ps
module flash_extended_query_rom_tb;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        clk_en = 1'b1;
   logic [2:0]  address = 3'h0;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [15:0] array_rdata = 16'h0;
   logic [7:0]  status_byte = 8'h0;
   wire  [31:0] readdata;
   wire         waitrequest;
   wire  [8:0]  pin_addr;
   wire         pin_ce_n;
   wire         pin_oe_n;
   wire  [15:0] dq_out;
   wire         dq_oe;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   int ctrl_m = 0;
   int qaddr_m = 'h10A;
   int cnt_m = 0;
   int a;
   logic [15:0] pd;
   logic [31:0] feat;
   logic [7:0]  rom [0:12] = '{8'h50, 8'h52, 8'h49, 8'h31, 8'h35, 8'hE6, 8'h01, 8'h00, 8'h00, 8'h01, 8'h03, 8'h00, 8'h30};
   flash_extended_query_rom i_flash_extended_query_rom (.ref_clk, .rst_n, .clk_en, .address, .read, .write,
      .writedata, .readdata, .waitrequest, .pin_addr, .pin_ce_n, .pin_oe_n, .dq_out, .dq_oe, .array_rdata, .status_byte);
   host_query_reader i_host (.ref_clk, .pin_addr, .pin_ce_n, .pin_oe_n, .dq_out, .dq_oe);
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         wrap_up();
      end
   end
   ////////////////////////////////////////
   function automatic logic [15:0] src(input int q);
      if (ctrl_m[0])
         src = (q >= 'h10A && q <= 'h116) ? {8'h00, rom[q - 'h10A]} : 16'h0000;
      else if (ctrl_m[1])
         src = {8'h00, status_byte};
      else
         src = array_rdata;
   endfunction
   function automatic logic [31:0] ereg(input int ad);
      case (ad)
         0: ereg = ctrl_m;
         1: ereg = qaddr_m;
         2: ereg = {16'h0000, src(qaddr_m)};
         3: ereg = ctrl_m;
         4: ereg = cnt_m & 'hFFFF;
         5: ereg = 32'h000001E6;
         default: ereg = 32'h0;
      endcase
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [2:0] ad, input logic [31:0] wd);
      @(posedge ref_clk);
      address <= ad;
      writedata <= wd;
      read <= ~w;
      write <= w;
      @(posedge ref_clk);
      while (waitrequest !== 1'b0)
         @(posedge ref_clk);
      if (!w)
         check(readdata, ereg(ad));
      read <= 1'b0;
      write <= 1'b0;
      if (w && ad == 3'h0)
         ctrl_m = wd & 3;
      if (w && ad == 3'h1)
         qaddr_m = wd & 'h1FF;
      if (!w && ad == 3'h2 && ctrl_m[0])
         qaddr_m = (qaddr_m + 1) & 'h1FF;
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////
   initial
   begin
      feat = $urandom(32'hAC040F4A);
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (a = 0; a < 8; a++) acc(1'b0, a[2:0], 32'h0);
      acc(1'b1, 3'h5, 32'hFFFFFFFF);
      acc(1'b0, 3'h5, 32'h0);
      acc(1'b1, 3'h0, 32'h1);
      acc(1'b1, 3'h1, 32'h109);
      for (a = 0; a < 15; a++) acc(1'b0, 3'h2, 32'h0);
      for (a = 0; a < 4; a++)
      begin
         i_host.fetch(9'h10F + a[8:0], pd);
         cnt_m++;
         feat[8 * a +: 8] = pd[7:0];
      end
      check(feat, 32'h000001E6);
      if (feat[31] === 1'b1)
      begin
         i_host.fetch(9'h113, pd);
         cnt_m++;
      end
      clk_en <= 1'b0;
      repeat (5) @(posedge ref_clk);
      clk_en <= 1'b1;
      acc(1'b0, 3'h4, 32'h0);
      acc(1'b0, 3'h1, 32'h0);
      for (int i = 0; i < 24; i++)
      begin
         array_rdata <= 16'($urandom);
         status_byte <= 8'($urandom);
         i_host.slow = i % 3;
         acc(1'b1, 3'h0, $urandom_range(3, 0));
         a = $urandom_range('h11A, 'h105);
         acc(1'b1, 3'h1, a);
         i_host.fetch(a[8:0], pd);
         cnt_m++;
         check({16'h0000, pd}, {16'h0000, src(a)});
         acc(1'b0, 3'h2, 32'h0);
         acc(1'b0, 3'h3, 32'h0);
         acc(1'b0, 3'h4, 32'h0);
      end
      wrap_up();
   end
endmodule // flash_extended_query_rom_tb

/* verif/host_query_reader.sv */
// host side model reading query bytes over the flash pins
// assumes the testbench calls fetch one read at a time
`timescale 1ns/1ps
module host_query_reader
(
   input  wire        ref_clk,
   output logic [8:0] pin_addr,
   output logic       pin_ce_n,
   output logic       pin_oe_n,
   input  wire [15:0] dq_out,
   input  wire        dq_oe
);
   int slow = 0;
   initial
   begin
      pin_addr = 9'h000;
      pin_ce_n = 1'b1;
      pin_oe_n = 1'b1;
   end
   task automatic fetch(input logic [8:0] qa, output logic [15:0] q);
      @(posedge ref_clk);
      pin_addr <= qa;
      pin_ce_n <= 1'b0;
      pin_oe_n <= 1'b0;
      while (dq_oe !== 1'b1)
         @(posedge ref_clk);
      repeat (4 + slow) @(posedge ref_clk);
      q = dq_out;
      pin_ce_n <= 1'b1;
      pin_oe_n <= 1'b1;
      pin_addr <= ~qa;
      repeat (8) @(posedge ref_clk);
   endtask
endmodule // host_query_reader

/* verif/query_rom_checker.sv */
// checker for the query table block, bound to its top module
// assumes clk_en held high and control writes apart from pin reads
`timescale 1ns/1ps
module query_rom_checker
(
   input wire        ref_clk,
   input wire        rst_n,
   input wire [2:0]  address,
   input wire        read,
   input wire        write,
   input wire [31:0] writedata,
   input wire [31:0] readdata,
   input wire        waitrequest,
   input wire        pin_ce_n,
   input wire        pin_oe_n,
   input wire [15:0] dq_out,
   input wire        dq_oe,
   input wire [7:0]  status_byte
);
   reg [1:0] mode_reg;
   always @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         mode_reg <= 2'h0;
      else if (write && !waitrequest && address == 3'h0)
         mode_reg <= writedata[1:0];
   ////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence rd_ans; read && !waitrequest; endsequence
   sequence pin_rd; (!pin_ce_n && !pin_oe_n) [*6]; endsequence
   a_feat_word: assert property (rd_ans ##0 address == 3'h5 |-> readdata == 32'h000001E6)
      else $error("feature word wrong");
   a_qdata_upper: assert property (rd_ans ##0 (address == 3'h2 && mode_reg != 2'h0) |-> readdata[31:8] == 24'h0)
      else $error("query data upper bits set");
   a_susp_status: assert property (rd_ans ##0 (address == 3'h2 && mode_reg == 2'h2) |-> readdata[7:0] == $past(status_byte))
      else $error("status not returned while suspended");
   a_status_mode: assert property (rd_ans ##0 address == 3'h3 |-> readdata[1:0] == mode_reg)
      else $error("status mode bits wrong");
   a_dq_upper: assert property (mode_reg[0] && dq_oe |-> dq_out[15:8] == 8'h00)
      else $error("upper data pins not zero");
   a_pin_drive: assert property (pin_rd |-> ##[0:2] dq_oe)
      else $error("pin read not answered");
   a_pin_release: assert property (pin_ce_n [*7] |-> !dq_oe)
      else $error("data pins driven when idle");
   a_wait_pulse: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not one cycle");
   a_read_hold: assert property (!$fell(waitrequest) |-> $stable(readdata))
      else $error("read data changed without answer");
endmodule // query_rom_checker
bind flash_extended_query_rom query_rom_checker i_query_rom_checker (.ref_clk, .rst_n, .address, .read, .write,
   .writedata, .readdata, .waitrequest, .pin_ce_n, .pin_oe_n, .dq_out, .dq_oe, .status_byte);
